// [bert_chk.sv]
// port assertions of the bit error rate tester
`include "bert_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module bert_chk (
	input wire logic                    clk,
	input wire logic                    nrst,
	input wire logic [7:0]              regAddr,
	input wire logic [15:0]             regWrData,
	input wire logic                    regWr,
	input wire logic                    regRd,
	input wire logic [15:0]             regRdData,
	input wire logic                    txBitEn,
	input wire bert_pkg::bert_line_type txLine
);
	import bert_pkg::*;
	logic [15:0] sh [0:7];
	logic        firstPend;
	wire         regHit = regWr && regAddr[7:4] == 4'h6;
	wire         rdStat = regRd && regAddr == `BERT_OFF_STAT;
	////////////////////////////////////////////////////////////////
	// shadow of written halfwords; only the writable ones are looked at
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			for (int i = 0; i < 8; i++) sh[i] <= 16'h0000;
		end else if (regHit) begin
			sh[regAddr[3:1]] <= regWrData;
		end
	end
	// set by a load rise, so a bit taken in the same cycle is not the first
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) firstPend <= 1'b0;
		else firstPend <= $rose(sh[0][1]) || (firstPend && !txBitEn);
	end
	////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	a_rd_idle_zero: assert property (!$past(regRd) |-> regRdData == 16'h0000)
		else $error("read data not zero outside read cycle");
	a_tx_en_delay: assert property ($past(nrst) |-> txLine.bitEn == $past(txBitEn))
		else $error("transmit bit enable latency wrong");
	a_tx_data_hold: assert property ($past(nrst) && !txLine.bitEn |-> $stable(txLine.data))
		else $error("transmit data moved between bits");
	a_status_unused: assert property (rdStat |=> regRdData[15:4] == 12'h000 && !regRdData[2])
		else $error("unused status bits not zero");
	a_unmapped_zero: assert property (regRd && regAddr == 8'h70 |=> regRdData == 16'h0000)
		else $error("unmapped read not zero");
	a_seed_readback: assert property (regWr && regAddr == `BERT_OFF_SEEDHI ##1 regRd
		&& regAddr == `BERT_OFF_SEEDHI |=> regRdData == $past(regWrData, 2))
		else $error("seed high readback wrong");
	a_teicr_readback: assert property (regWr && regAddr == `BERT_OFF_TEICR ##1 regRd
		&& regAddr == `BERT_OFF_TEICR |=> regRdData == ($past(regWrData, 2) & 16'h003F))
		else $error("insertion control readback wrong");
	a_done_low_req: assert property (rdStat && sh[0][7:6] == 2'b00 && $past(sh[0][7:6]) == 2'b00
		&& $past(sh[0][7:6], 2) == 2'b00 |=> !regRdData[3])
		else $error("update done high while request low");
	a_first_bit_msb: assert property (firstPend && txBitEn && sh[1][4:0] == 5'h1F
		&& sh[4][5:1] == 5'h00 && !sh[0][0] |=> txLine.data == sh[3][15])
		else $error("first bit after load not seed msb");
endmodule

bind bert_top bert_chk i_bert_chk (
	.clk(clk), .nrst(nrst), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
	.regRd(regRd), .regRdData(regRdData), .txBitEn(txBitEn), .txLine(txLine)
);
`default_nettype wire

// [bert_framer.sv]
// line-side framer model: bit opportunities and receive loopback
`timescale 1ns/1ps
`default_nettype none

module bert_framer (
	input  wire logic                    clk,
	input  wire logic                    nrst,
	input  wire logic                    run,
	input  wire logic                    slow,
	input  wire bert_pkg::bert_line_type txLine,
	output logic                         txBitEn,
	output bert_pkg::bert_line_type      rxLine
);
	import bert_pkg::*;
	logic [4:0] gapCnt_r;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			gapCnt_r <= 5'h00;
			txBitEn <= 1'b0;
			rxLine <= 2'h0;
		end else begin
			gapCnt_r <= gapCnt_r + 5'h01;
			txBitEn <= run && (!slow || gapCnt_r == 5'h00);
			rxLine.bitEn <= txLine.bitEn;
			// toggles between bits so a stale bit never looks fresh
			rxLine.data <= txLine.bitEn ? txLine.data : ~rxLine.data;
		end
	end
endmodule
`default_nettype wire

// [bert_pgen.sv]
// pattern generator: 32-stage shift register with length and feedback taps
`include "bert_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module bert_pgen (
	input  wire logic              clk,
	input  wire logic              nrst,
	input  wire logic              load,
	input  wire logic              step,
	input  wire logic              useExt,
	input  wire logic              extBit,
	input  wire logic [31:0]       seed,
	input  wire bert_pkg::bert_pat_type cfg,
	output logic                   outBit,
	output logic                   nextBit
);
	import bert_pkg::*;

	logic [31:0] state_r;
	logic        feedBit;

	// stage k sits at index k-1, so tap field values index directly
	assign outBit  = state_r[cfg.lenTap];
	assign nextBit = cfg.prbs ? (state_r[cfg.lenTap] ^ state_r[cfg.fbTap])
		: state_r[cfg.lenTap];
	assign feedBit = useExt ? extBit : nextBit;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_r <= `BERT_RST_SEED;
		end else if (load) begin
			state_r <= seed;
		end else if (step) begin
			state_r <= {state_r[30:0], feedBit};
		end
	end

endmodule
`default_nettype wire

// [bert_pkg.sv]
// types shared by the bit error rate tester files
package bert_pkg;

	typedef struct packed {
		logic bitEn;
		logic data;
	} bert_line_type;

	typedef struct packed {
		logic       prbs;
		logic [4:0] lenTap;
		logic [4:0] fbTap;
	} bert_pat_type;

	typedef enum logic {SYNC_HUNT, SYNC_LOCKED} bert_sync_type;

endpackage

// [bert_regs.svh]
// register offsets, field positions, reset values and counts of the bit error rate tester
`ifndef BERT_REGS_SVH
`define BERT_REGS_SVH

`define BERT_OFF_CTRL        8'h60
`define BERT_OFF_PCFG        8'h62
`define BERT_OFF_SEEDLO      8'h64
`define BERT_OFF_SEEDHI      8'h66
`define BERT_OFF_TEICR       8'h68
`define BERT_OFF_STAT        8'h6C

`define BERT_CTRL_UPDSEL     7
`define BERT_CTRL_LOCREQ     6
`define BERT_CTRL_RXLOAD     5
`define BERT_CTRL_RXINV      4
`define BERT_CTRL_RESYNC     3
`define BERT_CTRL_ARDIS      2
`define BERT_CTRL_TXLOAD     1
`define BERT_CTRL_TXINV      0

`define BERT_PCFG_FB_MSB     12
`define BERT_PCFG_FB_LSB     8
`define BERT_PCFG_PTS        5
`define BERT_PCFG_LEN_MSB    4
`define BERT_PCFG_LEN_LSB    0
`define BERT_PCFG_MASK       16'h1F3F

`define TRANSMIT_ERROR_INSERTION_CONTROL_RATE_MSB  5
`define TRANSMIT_ERROR_INSERTION_CONTROL_RATE_LSB  3
`define TRANSMIT_ERROR_INSERTION_CONTROL_SEN       2
`define TRANSMIT_ERROR_INSERTION_CONTROL_SOFT      1
`define TRANSMIT_ERROR_INSERTION_CONTROL_SRC       0
`define TRANSMIT_ERROR_INSERTION_CONTROL_MASK      16'h003F

`define BERT_STAT_DONE       3
`define BERT_STAT_NZ         1
`define BERT_STAT_OOS        0

`define BERT_RST_REG         16'h0000
`define BERT_RST_SEED        32'h0000_0000

`define BERT_SYNC_MATCHES    6'h20
`define BERT_WIN_LAST        6'h3F
`define BERT_MISM_LIMIT      3'h6
`define BERT_ERRCNT_MAX      24'hFFFFFF

`endif

// [bert_tb.sv]
// self-checking testbench of the bit error rate tester
`include "bert_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module testbench;
	import bert_pkg::*;
	localparam logic [31:0] SEED = 32'hA5C3_0F96;
	logic          clk;
	logic          nrst;
	logic [7:0]    regAddr;
	logic [15:0]   regWrData;
	logic          regWr;
	logic          regRd;
	logic [15:0]   regRdData;
	logic          txBitEn;
	logic          run;
	logic          slow;
	logic          extErrInsert;
	logic          globalUpdateReq;
	bert_line_type txLine;
	bert_line_type rxLine;
	int            err_count;
	int            comparisons;
	int            bitIdx;
	int            errQ[$];

	bert_top i_bert_top (.clk(clk), .nrst(nrst), .regAddr(regAddr), .regWrData(regWrData),
		.regWr(regWr), .regRd(regRd), .regRdData(regRdData), .txBitEn(txBitEn),
		.txLine(txLine), .rxLine(rxLine), .extErrInsert(extErrInsert),
		.globalUpdateReq(globalUpdateReq));
	bert_framer i_bert_framer (.clk(clk), .nrst(nrst), .run(run), .slow(slow),
		.txLine(txLine), .txBitEn(txBitEn), .rxLine(rxLine));

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// index restarts only while the line is idle, so no race with this edge
	always @(posedge clk) begin
		if (txLine.bitEn === 1'b1) begin
			if (txLine.data !== SEED[31 - bitIdx % 32]) errQ.push_back(bitIdx);
			bitIdx++;
		end
	end
	////////////////////////////////////////////////////////////////
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		regAddr <= a;
		regWrData <= d;
		regWr <= 1'b1;
		@(posedge clk);
		regWr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		@(posedge clk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge clk);
		regRd <= 1'b0;
		@(posedge clk);
		d = regRdData;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [15:0] e);
		logic [15:0] d;
		rd(a, d);
		check(d, e);
	endtask
	// read issued straight after the write, no gap
	task automatic wrrd(input logic [7:0] a, input logic [15:0] d, input logic [15:0] e);
		wr(a, d);
		regRd <= 1'b1;
		@(posedge clk);
		regRd <= 1'b0;
		@(posedge clk);
		check(regRdData, e);
	endtask
	task automatic pulse_ext;
		extErrInsert <= 1'b1;
		repeat (4) @(posedge clk);
		extErrInsert <= 1'b0;
	endtask
	task automatic finish_test;
		if (err_count == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	task automatic t_reset;
		rdc(`BERT_OFF_SEEDLO, 16'h0000);
		rdc(`BERT_OFF_TEICR, 16'h0000);
		rdc(`BERT_OFF_STAT, 16'h0001);
		rdc(8'h70, 16'h0000);
		wrrd(`BERT_OFF_TEICR, 16'hFFC0, 16'h0000);
	endtask
	task automatic t_load;
		wrrd(`BERT_OFF_SEEDHI, SEED[31:16], SEED[31:16]);
		wrrd(`BERT_OFF_SEEDLO, SEED[15:0], SEED[15:0]);
		wr(`BERT_OFF_PCFG, 16'h003F);
		wr(`BERT_OFF_CTRL, 16'h0022);
		rdc(`BERT_OFF_STAT, 16'h0001);
		bitIdx = 0;
		errQ.delete();
		run <= 1'b1;
		repeat (100) @(posedge clk);
		check(errQ.size(), 0);
		rdc(`BERT_OFF_STAT, 16'h0000);
	endtask
	task automatic t_single;
		errQ.delete();
		wr(`BERT_OFF_TEICR, 16'h0004);
		wr(`BERT_OFF_TEICR, 16'h0006);
		wr(`BERT_OFF_TEICR, 16'h0004);
		repeat (40) @(posedge clk);
		check(errQ.size(), 1);
		rdc(`BERT_OFF_STAT, 16'h0002);
		wr(`BERT_OFF_CTRL, 16'h0040);
		repeat (4) @(posedge clk);
		rdc(`BERT_OFF_STAT, 16'h0008);
		wr(`BERT_OFF_CTRL, 16'h0000);
		rdc(`BERT_OFF_STAT, 16'h0000);
		// same handshake through the global request path
		wr(`BERT_OFF_CTRL, 16'h0080);
		globalUpdateReq <= 1'b1;
		repeat (4) @(posedge clk);
		rdc(`BERT_OFF_STAT, 16'h0008);
		globalUpdateReq <= 1'b0;
		rdc(`BERT_OFF_STAT, 16'h0000);
		wr(`BERT_OFF_CTRL, 16'h0000);
	endtask
	task automatic t_toggle;
		slow <= 1'b1;
		repeat (70) @(posedge clk);
		errQ.delete();
		@(posedge clk iff txBitEn === 1'b1);
		wr(`BERT_OFF_TEICR, 16'h0006);
		wr(`BERT_OFF_TEICR, 16'h0004);
		wr(`BERT_OFF_TEICR, 16'h0006);
		wr(`BERT_OFF_TEICR, 16'h0004);
		repeat (100) @(posedge clk);
		check(errQ.size(), 1);
	endtask
	task automatic t_ext;
		errQ.delete();
		wr(`BERT_OFF_TEICR, 16'h0005);
		pulse_ext();
		wr(`BERT_OFF_TEICR, 16'h0007);
		wr(`BERT_OFF_TEICR, 16'h0005);
		repeat (100) @(posedge clk);
		check(errQ.size(), 1);
		errQ.delete();
		wr(`BERT_OFF_TEICR, 16'h0001);
		pulse_ext();
		wr(`BERT_OFF_TEICR, 16'h0000);
		wr(`BERT_OFF_TEICR, 16'h0002);
		wr(`BERT_OFF_TEICR, 16'h0000);
		repeat (100) @(posedge clk);
		check(errQ.size(), 0);
	endtask
	task automatic t_rate;
		logic [15:0] d;
		int          n100 = 0;
		slow <= 1'b0;
		errQ.delete();
		wr(`BERT_OFF_TEICR, 16'h0008);
		repeat (150) @(posedge clk);
		wr(`BERT_OFF_TEICR, 16'h0010);
		rd(`BERT_OFF_STAT, d);
		check(d[0], 1'b1);
		repeat (250) @(posedge clk);
		wr(`BERT_OFF_TEICR, 16'h0000);
		repeat (400) @(posedge clk);
		for (int i = 1; i < errQ.size(); i++) begin
			if (errQ[i] - errQ[i - 1] == 100) n100++;
			else check(errQ[i] - errQ[i - 1], n100 ? 100 : 10);
		end
		check(n100, 3);
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		#20000;
		err_count++;
		finish_test();
	end
	initial begin
		nrst = 1'b0;
		regAddr = 8'h00;
		regWrData = 16'h0000;
		regWr = 1'b0;
		regRd = 1'b0;
		run = 1'b0;
		slow = 1'b0;
		extErrInsert = 1'b0;
		globalUpdateReq = 1'b0;
		err_count = 0;
		comparisons = 0;
		bitIdx = 0;
		repeat (5) @(posedge clk);
		nrst <= 1'b1;
		t_reset();
		t_load();
		t_single();
		t_toggle();
		t_ext();
		t_rate();
		finish_test();
	end
endmodule
`default_nettype wire

// [bert_top.sv]
// bit error rate tester: registers, transmit insertion, receive sync and error checking
`include "bert_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module bert_top (
	input  wire logic                    clk,
	input  wire logic                    nrst,
	input  wire logic [7:0]              regAddr,
	input  wire logic [15:0]             regWrData,
	input  wire logic                    regWr,
	input  wire logic                    regRd,
	output logic      [15:0]             regRdData,
	input  wire logic                    txBitEn,
	output bert_pkg::bert_line_type      txLine,
	input  wire bert_pkg::bert_line_type rxLine,
	input  wire logic                    extErrInsert,
	input  wire logic                    globalUpdateReq
);
	import bert_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// register file

	logic [15:0]   ctrl_r;
	logic [15:0]   pcfg_r;
	logic [31:0]   seed_r;
	logic [15:0]   teicr_r;
	logic [15:0]   ctrlPrev_r;
	logic          wrCtrl;
	logic          wrPcfg;
	logic          wrSeedLo;
	logic          wrSeedHi;
	logic          wrTeicr;
	logic          rdHit;
	logic [15:0]   statWord;
	logic [15:0]   rdMux;

	assign wrCtrl   = regWr && (regAddr == `BERT_OFF_CTRL);
	assign wrPcfg   = regWr && (regAddr == `BERT_OFF_PCFG);
	assign wrSeedLo = regWr && (regAddr == `BERT_OFF_SEEDLO);
	assign wrSeedHi = regWr && (regAddr == `BERT_OFF_SEEDHI);
	assign wrTeicr  = regWr && (regAddr == `BERT_OFF_TEICR);

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ctrl_r     <= `BERT_RST_REG;
			pcfg_r     <= `BERT_RST_REG;
			seed_r     <= `BERT_RST_SEED;
			teicr_r    <= `BERT_RST_REG;
			ctrlPrev_r <= `BERT_RST_REG;
		end else begin
			ctrlPrev_r <= ctrl_r;
			if (wrCtrl) ctrl_r <= {8'h00, regWrData[7:0]};
			if (wrPcfg) pcfg_r <= regWrData & `BERT_PCFG_MASK;
			if (wrSeedLo) seed_r[15:0] <= regWrData;
			if (wrSeedHi) seed_r[31:16] <= regWrData;
			if (wrTeicr) teicr_r <= regWrData & `TRANSMIT_ERROR_INSERTION_CONTROL_MASK;
		end
	end

	// rising edges of control bits, seen one cycle after the write lands
	logic txLoadRise;
	logic rxLoadRise;
	logic resyncRise;

	assign txLoadRise = ctrl_r[`BERT_CTRL_TXLOAD] && !ctrlPrev_r[`BERT_CTRL_TXLOAD];
	assign rxLoadRise = ctrl_r[`BERT_CTRL_RXLOAD] && !ctrlPrev_r[`BERT_CTRL_RXLOAD];
	assign resyncRise = ctrl_r[`BERT_CTRL_RESYNC] && !ctrlPrev_r[`BERT_CTRL_RESYNC];

	bert_pat_type pcfgNow;

	assign pcfgNow.prbs   = !pcfg_r[`BERT_PCFG_PTS];
	assign pcfgNow.lenTap = pcfg_r[`BERT_PCFG_LEN_MSB:`BERT_PCFG_LEN_LSB];
	assign pcfgNow.fbTap  = pcfg_r[`BERT_PCFG_FB_MSB:`BERT_PCFG_FB_LSB];

	////////////////////////////////////////////////////////////////////////////
	// external insertion pin synchroniser

	logic extMeta_r;
	logic extSync_r;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			extMeta_r <= 1'b0;
			extSync_r <= 1'b0;
		end else begin
			extMeta_r <= extErrInsert;
			extSync_r <= extMeta_r;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// transmit generator and error insertion

	bert_pat_type txCfg_r;
	logic         txGenBit;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			txCfg_r <= '0;
		end else if (txLoadRise) begin
			txCfg_r <= pcfgNow;
		end
	end

	bert_pgen txGen (
		.clk     (clk),
		.nrst    (nrst),
		.load    (txLoadRise),
		.step    (txBitEn && !txLoadRise),
		.useExt  (1'b0),
		.extBit  (1'b0),
		.seed    (seed_r),
		.cfg     (txLoadRise ? pcfgNow : txCfg_r),
		.outBit  (txGenBit),
		.nextBit ()
	);

	function automatic logic [23:0] decadeLast(input logic [2:0] n);
		case (n)
			3'h1:    decadeLast = 24'h000009;
			3'h2:    decadeLast = 24'h000063;
			3'h3:    decadeLast = 24'h0003E7;
			3'h4:    decadeLast = 24'h00270F;
			3'h5:    decadeLast = 24'h01869F;
			3'h6:    decadeLast = 24'h0F423F;
			3'h7:    decadeLast = 24'h98967F;
			default: decadeLast = 24'h000000;
		endcase
	endfunction

	logic [2:0]  curRate_r;
	logic [23:0] rateCnt_r;
	logic [2:0]  newRate;
	logic        rateHit;

	assign newRate = teicr_r[`TRANSMIT_ERROR_INSERTION_CONTROL_RATE_MSB:`TRANSMIT_ERROR_INSERTION_CONTROL_RATE_LSB];
	assign rateHit = txBitEn && (curRate_r != 3'h0)
		&& (rateCnt_r == decadeLast(curRate_r));

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			curRate_r <= 3'h0;
			rateCnt_r <= 24'h000000;
		end else if (curRate_r == 3'h0) begin
			// idle: a written nonzero code starts counting at once
			curRate_r <= newRate;
			rateCnt_r <= 24'h000000;
		end else if (rateHit) begin
			curRate_r <= newRate;
			rateCnt_r <= 24'h000000;
		end else if (txBitEn) begin
			rateCnt_r <= rateCnt_r + 24'h000001;
		end
	end

	// the source mux sits before the edge detector, so a select change
	// while the new source is high reads as a rise
	logic trigLevel;
	logic trigPrev_r;
	logic trigRise;
	logic singleEn;
	logic single_r;
	logic errNow;

	assign singleEn  = teicr_r[`TRANSMIT_ERROR_INSERTION_CONTROL_SEN];
	assign trigLevel = teicr_r[`TRANSMIT_ERROR_INSERTION_CONTROL_SRC] ? extSync_r
		: teicr_r[`TRANSMIT_ERROR_INSERTION_CONTROL_SOFT];
	assign trigRise  = trigLevel && !trigPrev_r;
	assign errNow    = rateHit || (txBitEn && single_r && singleEn);

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			trigPrev_r <= 1'b0;
			single_r   <= 1'b0;
		end else begin
			trigPrev_r <= trigLevel;
			// repeated rises merge into one pending error; a new rise wins
			single_r <= (trigRise && singleEn)
				|| (single_r && !txBitEn);
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			txLine <= '0;
		end else begin
			txLine.bitEn <= txBitEn;
			if (txBitEn) begin
				txLine.data <= txGenBit ^ errNow ^ ctrl_r[`BERT_CTRL_TXINV];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// receive checker

	bert_pat_type  rxCfg_r;
	bert_sync_type syncState_r;
	logic          rxBit;
	logic          rxPredict;
	logic          rxMismatch;
	logic          hunting;
	logic          forceHunt;
	logic [5:0]    matchCnt_r;
	logic [5:0]    winCnt_r;
	logic [2:0]    mismCnt_r;
	logic          tooMany;

	assign rxBit      = rxLine.data ^ ctrl_r[`BERT_CTRL_RXINV];
	assign hunting    = (syncState_r == SYNC_HUNT);
	assign rxMismatch = rxLine.bitEn && (rxBit != rxPredict);
	assign forceHunt  = rxLoadRise || resyncRise;
	assign tooMany    = rxMismatch && (mismCnt_r >= `BERT_MISM_LIMIT - 3'h1)
		&& !ctrl_r[`BERT_CTRL_ARDIS];

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rxCfg_r <= '0;
		end else if (rxLoadRise) begin
			rxCfg_r <= pcfgNow;
		end
	end

	// while hunting the generator is filled from the line itself
	bert_pgen rxGen (
		.clk     (clk),
		.nrst    (nrst),
		.load    (rxLoadRise),
		.step    (rxLine.bitEn && !rxLoadRise),
		.useExt  (hunting),
		.extBit  (rxBit),
		.seed    (seed_r),
		.cfg     (rxLoadRise ? pcfgNow : rxCfg_r),
		.outBit  (),
		.nextBit (rxPredict)
	);

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			syncState_r <= SYNC_HUNT;
			matchCnt_r  <= 6'h00;
			winCnt_r    <= 6'h00;
			mismCnt_r   <= 3'h0;
		end else if (forceHunt) begin
			syncState_r <= SYNC_HUNT;
			matchCnt_r  <= 6'h00;
		end else if (rxLine.bitEn) begin
			case (syncState_r)
				SYNC_HUNT: begin
					matchCnt_r <= rxMismatch ? 6'h00 : matchCnt_r + 6'h01;
					winCnt_r   <= 6'h00;
					mismCnt_r  <= 3'h0;
					if (!rxMismatch && matchCnt_r == `BERT_SYNC_MATCHES - 6'h01) begin
						syncState_r <= SYNC_LOCKED;
					end
				end
				SYNC_LOCKED: begin
					winCnt_r <= winCnt_r + 6'h01;
					if (tooMany) begin
						syncState_r <= SYNC_HUNT;
						matchCnt_r  <= 6'h00;
					end
					if (winCnt_r == `BERT_WIN_LAST) begin
						mismCnt_r <= 3'h0;
					end else if (rxMismatch && mismCnt_r != 3'h7) begin
						mismCnt_r <= mismCnt_r + 3'h1;
					end
				end
				default: syncState_r <= SYNC_HUNT;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// error count and counter update

	logic        updLevel;
	logic        updPrev_r;
	logic        updRise;
	logic        updFall;
	logic        snapPend_r;
	logic        done_r;
	logic [23:0] errCnt_r;
	logic        countErr;

	assign updLevel = ctrl_r[`BERT_CTRL_UPDSEL] ? globalUpdateReq
		: ctrl_r[`BERT_CTRL_LOCREQ];
	assign updRise  = updLevel && !updPrev_r;
	assign updFall  = !updLevel && updPrev_r;
	assign countErr = rxMismatch && !hunting;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			updPrev_r  <= 1'b0;
			snapPend_r <= 1'b0;
			done_r     <= 1'b0;
			errCnt_r   <= 24'h000000;
		end else begin
			updPrev_r  <= updLevel;
			snapPend_r <= updRise;
			if (updFall) begin
				done_r <= 1'b0;
			end else if (snapPend_r) begin
				done_r <= 1'b1;
			end
			// a snapshot restarts the count but keeps an error of that cycle
			if (updRise) begin
				errCnt_r <= {23'h000000, countErr};
			end else if (countErr && errCnt_r != `BERT_ERRCNT_MAX) begin
				errCnt_r <= errCnt_r + 24'h000001;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// read side

	always_comb begin
		statWord = 16'h0000;
		statWord[`BERT_STAT_DONE] = done_r;
		statWord[`BERT_STAT_NZ]   = (errCnt_r != 24'h000000);
		statWord[`BERT_STAT_OOS]  = hunting;
	end

	assign rdHit = regRd;
	assign rdMux = (regAddr == `BERT_OFF_CTRL)   ? ctrl_r
		: (regAddr == `BERT_OFF_PCFG)   ? pcfg_r
		: (regAddr == `BERT_OFF_SEEDLO) ? seed_r[15:0]
		: (regAddr == `BERT_OFF_SEEDHI) ? seed_r[31:16]
		: (regAddr == `BERT_OFF_TEICR)  ? teicr_r
		: (regAddr == `BERT_OFF_STAT)   ? statWord
		: 16'h0000;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			regRdData <= 16'h0000;
		end else if (rdHit) begin
			regRdData <= rdMux;
		end else begin
			regRdData <= 16'h0000;
		end
	end

endmodule
`default_nettype wire
